// ---- include/flash_ctrl_defs.svh ----
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

// timing figures and derived cycle counts (clock 10 MHz)
`define CLK_PERIOD_NS 100
`define BOOT_RESTORE_S 10
`define BOOT_RESTORE_CYC (`BOOT_RESTORE_S * 64'd1000000000 / `CLK_PERIOD_NS)
`define PROGRAM_CYC 16
`define ERASE_CYC 32
`define NVM_CYC 4
// geometry defaults
`define BANK_COUNT 2
`define PAGES_PER_BANK 1024
`define PAGE_BYTES 256
`define REGION_PAGES 64
`define REGION_COUNT 32
`define BUF_BYTES_LARGE 256
`define BUF_BYTES_SMALL 128
// general purpose bit positions
`define GP_BROWNOUT_EN 0
`define GP_BROWNOUT_RST 1
// factory calibration value (arbitrary)
`define CAL_DEFAULT 8'hA5
// wait-state reset value
`define WAIT_RESET 2'h1

`endif

// ---- include/flash_ctrl_pkg.sv ----
package flash_ctrl_pkg;
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_PAGE_PROGRAM = 4'h1,
		CMD_PAGE_ERASE = 4'h2,
		CMD_FULL_ERASE = 4'h3,
		CMD_SET_LOCK = 4'h4,
		CMD_CLEAR_LOCK = 4'h5,
		CMD_SET_GP = 4'h6,
		CMD_CLEAR_GP = 4'h7,
		CMD_SET_SECURITY = 4'h8
	} command_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUSY = 2'h1,
		ST_DONE = 2'h2
	} seq_state_t;

	// command request from the register user interface
	typedef struct packed {
		logic valid;
		command_t cmd;
		logic [10:0] page;
		logic gpIndex;
	} cmd_req_t;

	// status reported back to software
	typedef struct packed {
		logic ready;
		logic lock_violation_flag;
		logic commandError;
		logic irq;
	} status_t;
endpackage

// ---- design/page_buffer.sv ----
`timescale 1ns/1ps
// page write buffer with registered read data
module page_buffer
	import flash_ctrl_pkg::*;
#(
	parameter int WORDS = 64
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// write side
	input wire logic wrEn,
	input wire logic [$clog2(WORDS)-1:0] wrAddr,
	input wire logic [31:0] wrData,
	// read side
	input wire logic [$clog2(WORDS)-1:0] rdAddr,
	output logic [31:0] rdData
);
	logic [31:0] mem [WORDS];

	// storage write and registered read
	always_ff @(posedge clock) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		if (!rstn) begin
			rdData <= 32'h0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end
endmodule

// ---- design/embedded_flash_controller.sv ----
`timescale 1ns/1ps
// Overview of operation
// - array is pages of 32-bit words, sized by banks, pages, page bytes
// - page-sized write buffer filled through a 32-bit port
// - array goes to standby whenever nothing reads or writes it
// - bus masters read the array and write the buffer; control is ported
// - software sets wait states and starts erase, program, nvm commands
// - done and error status reported, interrupts enabled separately
// - dual 32-bit prefetch buffer serves sequential halfword fetches
// - each bank has own sequencer; reads proceed in the idle bank
// - array split in lock regions of fixed pages, one lock bit each
// - erase or program into locked region aborts and flags lock error
// - lock error raises interrupt only when its enable bit is one
// - set-lock protects a region, clear-lock unprotects it
// - erase pin clears every lock bit
// - security bit blocks debug and fast programming port accesses
// - security set only by its command, never cleared by a command alone
// - security clears after erase pin high then full erase
// - two general bits with own set and clear commands, kept
// - general bit 0 enables brownout detector; erase pin clears it
// - general bit 1 enables brownout reset; erase pin clears it
// - eight calibration bits unwritable and unaffected by erase pin
// - test pin, lines 0,1 high, line 2 low enter fast programming
// - test pin and lines 0..2 high ten seconds restores boot program
`include "flash_ctrl_defs.svh"
module embedded_flash_controller
	import flash_ctrl_pkg::*;
#(
	parameter int BANKS = `BANK_COUNT,
	parameter int PAGES = `PAGES_PER_BANK,
	parameter int PAGE_BYTES = `PAGE_BYTES,
	parameter int REGION_PAGES = `REGION_PAGES,
	parameter longint BOOT_CYCLES = `BOOT_RESTORE_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// bus master read port
	input wire logic readReq,
	input wire logic [20:0] readAddr,
	input wire logic readFromDebug,
	input wire logic [31:0] arrayData,
	output logic [31:0] readData,
	output logic readValid,
	output logic readRefused,
	// bus master write-buffer port
	input wire logic bufWrite,
	input wire logic [5:0] bufWordAddr,
	input wire logic [31:0] bufWriteData,
	// command port
	input wire cmd_req_t cmdReq,
	input wire logic [1:0] waitStates,
	input wire logic lockErrIrqEn,
	input wire logic doneIrqEn,
	// external pins
	input wire logic erasePin,
	input wire logic factory_test_pin,
	input wire logic io_line_zero,
	input wire logic io_line_one,
	input wire logic io_line_two,
	// status and array controls
	output status_t flash_status_register,
	output logic [BANKS-1:0] bankStandby,
	output logic [BANKS-1:0] bankBusy,
	output logic [31:0] programData,
	output logic fast_programming_port,
	output logic bootRestore,
	output logic brownoutDetectorEn,
	output logic brownoutResetEn,
	output logic [7:0] calibration,
	output logic [BANKS*PAGES/REGION_PAGES-1:0] lockBits,
	output logic securityBit
);
	localparam int REGIONS = BANKS * PAGES / REGION_PAGES;
	localparam int BUF_WORDS = PAGE_BYTES / 4;
	localparam int PAGE_W = $clog2(BANKS * PAGES);
	localparam int REG_W = $clog2(REGIONS);

	typedef struct packed {
		seq_state_t [BANKS-1:0] seq;
		logic [BANKS-1:0][5:0] timer;
		logic [1:0] gp;
		logic [REGIONS-1:0] locks;
		logic security;
		logic erasePending;
		logic fullErase;
		logic ready;
		logic lockErr;
		logic cmdErr;
		logic irq;
		logic [1:0][31:0] prefetch;
		logic [1:0][18:0] pfTag;
		logic [1:0] pfValid;
		logic [1:0] waitCnt;
		logic reading;
		logic [20:0] rdAddr;
		logic [31:0] rdData;
		logic rdValid;
		logic refused;
		logic [BANKS-1:0] standby;
		logic fastProg;
		logic [63:0] bootCnt;
		logic boot;
		logic [7:0] cal;
		logic [BANKS-1:0] prog;
	} state_t;

	state_t cur;
	state_t next_cur;
	logic [31:0] bufRdData;

	// page write buffer sized to the page
	page_buffer #(.WORDS(BUF_WORDS)) writeBuffer (
		.clock(clock),
		.rstn(rstn),
		.wrEn(bufWrite),
		.wrAddr(bufWordAddr[$clog2(BUF_WORDS)-1:0]),
		.wrData(bufWriteData),
		.rdAddr(cur.timer[0][$clog2(BUF_WORDS)-1:0]),
		.rdData(bufRdData)
	);

	// command decode helpers
	logic [PAGE_W-1:0] cmdPage;
	logic [REG_W-1:0] cmdRegion;
	logic cmdBank;
	assign cmdPage = cmdReq.page[PAGE_W-1:0];
	assign cmdRegion = REG_W'(cmdPage / PAGE_W'(REGION_PAGES));
	assign cmdBank = (BANKS > 1) ? cmdPage[PAGE_W-1] : 1'b0;

	// next-state logic
	always_comb begin
		logic rdBank;
		logic hit0;
		logic hit1;
		logic lockHit;
		logic busyAny;
		rdBank = (BANKS > 1) ? cur.rdAddr[20] : 1'b0;
		hit0 = 1'b0;
		hit1 = 1'b0;
		lockHit = 1'b0;
		busyAny = |cur.prog;
		next_cur = cur;
		next_cur.rdValid = 1'b0;
		next_cur.refused = 1'b0;
		// sequencers per bank count down
		for (int b = 0; b < BANKS; b++) begin
			case (cur.seq[b])
				ST_IDLE: begin
					next_cur.prog[b] = 1'b0;
				end
				ST_BUSY: begin
					if (cur.timer[b] == 6'h0) begin
						next_cur.seq[b] = ST_DONE;
					end else begin
						next_cur.timer[b] = cur.timer[b] - 6'h1;
					end
				end
				ST_DONE: begin
					next_cur.seq[b] = ST_IDLE;
					next_cur.fullErase = 1'b0;
					next_cur.prog[b] = 1'b0;
					next_cur.ready = 1'b1;
					if (doneIrqEn) begin
						next_cur.irq = 1'b1;
					end
				end
				default: begin
					next_cur.seq[b] = ST_IDLE;
				end
			endcase
		end
		// full erase after erase pin releases security
		for (int b = 0; b < BANKS; b++) begin
			if (cur.seq[b] == ST_DONE && cur.erasePending &&
				cur.fullErase) begin
				next_cur.security = 1'b0;
				next_cur.erasePending = 1'b0;
			end
		end
		// accept a new command
		if (cmdReq.valid && cur.ready && !busyAny) begin
			next_cur.ready = 1'b0;
			lockHit = (cmdReq.cmd == CMD_FULL_ERASE) ? |cur.locks :
				cur.locks[cmdRegion];
			case (cmdReq.cmd)
				CMD_PAGE_PROGRAM, CMD_PAGE_ERASE, CMD_FULL_ERASE: begin
					if (lockHit) begin
						next_cur.ready = 1'b1;
						next_cur.lockErr = 1'b1;
						if (lockErrIrqEn) begin
							next_cur.irq = 1'b1;
						end
					end else begin
						next_cur.fullErase = (cmdReq.cmd == CMD_FULL_ERASE);
						for (int b = 0; b < BANKS; b++) begin
							if (cmdReq.cmd == CMD_FULL_ERASE ||
								b == int'(cmdBank)) begin
								next_cur.seq[b] = ST_BUSY;
								next_cur.prog[b] = 1'b1;
								next_cur.timer[b] =
									(cmdReq.cmd == CMD_PAGE_PROGRAM) ?
									6'(`PROGRAM_CYC) : 6'(`ERASE_CYC);
							end
						end
					end
				end
				CMD_SET_LOCK: begin
					next_cur.locks[cmdRegion] = 1'b1;
					next_cur.ready = 1'b1;
				end
				CMD_CLEAR_LOCK: begin
					next_cur.locks[cmdRegion] = 1'b0;
					next_cur.ready = 1'b1;
				end
				CMD_SET_GP: begin
					next_cur.gp[cmdReq.gpIndex] = 1'b1;
					next_cur.ready = 1'b1;
				end
				CMD_CLEAR_GP: begin
					next_cur.gp[cmdReq.gpIndex] = 1'b0;
					next_cur.ready = 1'b1;
				end
				CMD_SET_SECURITY: begin
					next_cur.security = 1'b1;
					next_cur.ready = 1'b1;
				end
				default: begin
					next_cur.cmdErr = 1'b1;
					next_cur.ready = 1'b1;
				end
			endcase
		end
		// erase pin clears locks and general bits
		if (erasePin) begin
			next_cur.locks = '0;
			next_cur.gp = 2'h0;
			next_cur.erasePending = cur.security;
		end
		// prefetch lookup
		hit0 = cur.pfValid[0] && cur.pfTag[0] == cur.rdAddr[20:2];
		hit1 = cur.pfValid[1] && cur.pfTag[1] == cur.rdAddr[20:2];
		if (readReq && !cur.reading) begin
			if (readFromDebug && cur.security) begin
				next_cur.refused = 1'b1;
			end else begin
				next_cur.reading = 1'b1;
				next_cur.rdAddr = readAddr;
				next_cur.waitCnt = waitStates;
			end
		end else if (cur.reading) begin
			if (hit0 || hit1) begin
				next_cur.rdData = hit0 ? cur.prefetch[0] : cur.prefetch[1];
				next_cur.rdValid = 1'b1;
				next_cur.reading = 1'b0;
			end else if (cur.prog[rdBank]) begin
				next_cur.waitCnt = cur.waitCnt; // bank busy, read waits
			end else if (cur.waitCnt != 2'h0) begin
				next_cur.waitCnt = cur.waitCnt - 2'h1;
			end else begin
				// fill the slot for this word only; the other slot keeps its contents
				next_cur.rdData = arrayData;
				next_cur.rdValid = 1'b1;
				next_cur.reading = 1'b0;
				next_cur.prefetch[cur.rdAddr[2]] = arrayData;
				next_cur.pfTag[cur.rdAddr[2]] = cur.rdAddr[20:2];
				next_cur.pfValid[cur.rdAddr[2]] = 1'b1;
			end
		end
		// writes or erases invalidate the prefetch
		if (busyAny) begin
			next_cur.pfValid = 2'h0;
		end
		// standby when neither read nor write touches a bank
		for (int b = 0; b < BANKS; b++) begin
			next_cur.standby[b] = !next_cur.prog[b] &&
				!(next_cur.reading && (BANKS == 1 ||
				int'(next_cur.rdAddr[20]) == b));
		end
		// pin strap entry of fast programming
		next_cur.fastProg = factory_test_pin && io_line_zero &&
			io_line_one && !io_line_two && !next_cur.security;
		// boot restore after strap held for the full time
		if (factory_test_pin && io_line_zero && io_line_one && io_line_two)
		begin
			if (cur.bootCnt < 64'(BOOT_CYCLES)) begin
				next_cur.bootCnt = cur.bootCnt + 64'h1;
			end else begin
				next_cur.boot = 1'b1;
			end
		end else begin
			next_cur.bootCnt = 64'h0;
		end
		next_cur.cal = `CAL_DEFAULT;
	end

	// state register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cur <= '0;
			cur.ready <= 1'b1;
			cur.cal <= `CAL_DEFAULT;
			cur.standby <= '1;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from state
	assign readData = cur.rdData;
	assign readValid = cur.rdValid;
	assign readRefused = cur.refused;
	assign flash_status_register = '{ready: cur.ready,
		lock_violation_flag: cur.lockErr, commandError: cur.cmdErr,
		irq: cur.irq};
	assign bankStandby = cur.standby;
	assign bankBusy = cur.prog;
	assign programData = bufRdData;
	assign fast_programming_port = cur.fastProg;
	assign bootRestore = cur.boot;
	assign brownoutDetectorEn = cur.gp[`GP_BROWNOUT_EN];
	assign brownoutResetEn = cur.gp[`GP_BROWNOUT_RST];
	assign calibration = cur.cal;
	assign lockBits = cur.locks;
	assign securityBit = cur.security;

	// locked program must abort with lock flag
	AST_LOCK_ABORT: assert property (@(posedge clock) disable iff (!rstn)
		cmdReq.valid && cur.ready && !(|cur.prog) &&
		cmdReq.cmd == CMD_PAGE_PROGRAM && cur.locks[cmdRegion]
		|=> cur.lockErr && cur.ready && !(|cur.prog))
		else $error("locked program not aborted");
	AST_LOCK_IRQ: assert property (@(posedge clock) disable iff (!rstn)
		$rose(cur.lockErr) && !$past(lockErrIrqEn) && !$past(doneIrqEn) &&
		!$past(cur.irq) |-> !cur.irq)
		else $error("lock irq without enable");
	AST_ERASE_PIN: assert property (@(posedge clock) disable iff (!rstn)
		erasePin |=> cur.locks == '0 && cur.gp == 2'h0)
		else $error("erase pin did not clear bits");
	AST_SECURE_REFUSE: assert property (@(posedge clock)
		disable iff (!rstn)
		readReq && !cur.reading && readFromDebug && cur.security
		|=> readRefused && !cur.reading)
		else $error("debug read allowed while secure");
	AST_SECURE_STICKY: assert property (@(posedge clock)
		disable iff (!rstn)
		cur.security && !cur.erasePending |=> cur.security)
		else $error("security cleared without erase pin");
	AST_READY_DROP: assert property (@(posedge clock) disable iff (!rstn)
		cmdReq.valid && cur.ready && !(|cur.prog) &&
		cmdReq.cmd == CMD_PAGE_ERASE && !cur.locks[cmdRegion]
		|=> !cur.ready ##[1:40] cur.ready)
		else $error("ready not cycled by erase");
	AST_STANDBY: assert property (@(posedge clock) disable iff (!rstn)
		!(|cur.prog) && !cur.reading |-> &cur.standby)
		else $error("array not in standby when idle");
	AST_FAST_PROG: assert property (@(posedge clock) disable iff (!rstn)
		factory_test_pin && io_line_zero && io_line_one && !io_line_two
		&& !securityBit ##1 !securityBit
		|-> fast_programming_port)
		else $error("fast programming not entered");
	AST_CAL: assert property (@(posedge clock) disable iff (!rstn)
		calibration == `CAL_DEFAULT)
		else $error("calibration bits changed");
endmodule

// ---- sim/flash_array_model.sv ----
`timescale 1ns/1ps
// array side of the read path: returns the word stored at the read address
module flash_array_model (
	// address presented by the controller
	input wire logic [20:0] readAddr,
	// word returned to the controller
	output logic [31:0] arrayData
);
	// each word encodes its own address and bank, so a misrouted read shows
	always_comb begin
		arrayData = {~readAddr[17:2], readAddr[17:2]};
		arrayData[31] = arrayData[31] ^ readAddr[20];
	end
endmodule

// ---- sim/embedded_flash_controller_bench.sv ----
`timescale 1ns/1ps
// command, read and pin scenarios against the flash controller
module embedded_flash_controller_bench
	import flash_ctrl_pkg::*;
;
	logic clock = 0;
	logic rstn = 0;
	logic readReq = 0;
	logic [20:0] readAddr = 0;
	logic readFromDebug = 0;
	logic [31:0] arrayData;
	logic [31:0] readData;
	logic readValid;
	logic readRefused;
	logic bufWrite = 0;
	logic [5:0] bufWordAddr = 0;
	logic [31:0] bufWriteData = 0;
	cmd_req_t cmdReq = '0;
	logic [1:0] waitStates = 2'h0;
	logic lockErrIrqEn = 0;
	logic doneIrqEn = 0;
	logic erasePin = 0;
	logic testPin = 0;
	logic ioZero = 0;
	logic ioOne = 0;
	logic ioTwo = 0;
	status_t flashStatus;
	logic [1:0] bankStandby;
	logic [1:0] bankBusy;
	logic [31:0] programData;
	logic fastPort;
	logic bootRestore;
	logic brownoutEn;
	logic brownoutRst;
	logic [7:0] calibration;
	logic [31:0] lockBits;
	logic securityBit;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	int lat;
	int lat2;

	// short boot-restore hold keeps the run brief
	embedded_flash_controller #(.BOOT_CYCLES(20)) dut (
		.clock(clock), .rstn(rstn),
		.readReq(readReq), .readAddr(readAddr),
		.readFromDebug(readFromDebug), .arrayData(arrayData),
		.readData(readData), .readValid(readValid),
		.readRefused(readRefused),
		.bufWrite(bufWrite), .bufWordAddr(bufWordAddr),
		.bufWriteData(bufWriteData),
		.cmdReq(cmdReq), .waitStates(waitStates),
		.lockErrIrqEn(lockErrIrqEn), .doneIrqEn(doneIrqEn),
		.erasePin(erasePin), .factory_test_pin(testPin),
		.io_line_zero(ioZero), .io_line_one(ioOne),
		.io_line_two(ioTwo),
		.flash_status_register(flashStatus), .bankStandby(bankStandby),
		.bankBusy(bankBusy), .programData(programData),
		.fast_programming_port(fastPort), .bootRestore(bootRestore),
		.brownoutDetectorEn(brownoutEn), .brownoutResetEn(brownoutRst),
		.calibration(calibration), .lockBits(lockBits),
		.securityBit(securityBit)
	);

	flash_array_model array (.readAddr(readAddr), .arrayData(arrayData));

	// 10 MHz clock
	always #50 clock = ~clock;

	// hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			$display("mismatch at %0t: run did not finish", $time);
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] expected,
			input string what);
		tests_run++;
		if (seen !== expected) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	// expected array word, worked out independently of the model
	function automatic logic [31:0] wordAt(input logic [20:0] a);
		return {~a[17:2], a[17:2]} ^ {a[20], 31'h0};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic doReset();
		@(posedge clock);
		rstn <= 0;
		repeat (16) @(posedge clock);
		rstn <= 1;
		tick(1);
	endtask

	// one command request, held for a single edge
	task automatic issue(input command_t c, input logic [10:0] pg,
			input logic gi);
		@(posedge clock);
		cmdReq <= '{valid: 1'b1, cmd: c, page: pg, gpIndex: gi};
		@(posedge clock);
		cmdReq <= '0;
		tick(1);
	endtask

	task automatic waitReady();
		int i;
		i = 0;
		while (flashStatus.ready !== 1'b1 && i < 300) begin
			tick(1);
			i++;
		end
		check(i < 300, 1, "ready never returned");
	endtask

	// read request pulse; n counts cycles until the answer
	task automatic readWord(input logic [20:0] a, input logic dbg,
			output int n);
		@(posedge clock);
		readReq <= 1;
		readAddr <= a;
		readFromDebug <= dbg;
		@(posedge clock);
		readReq <= 0;
		#1;
		n = 1;
		while (readValid !== 1'b1 && readRefused !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
	endtask

	task automatic setStraps(input logic [2:0] io, input logic t);
		@(posedge clock);
		{ioTwo, ioOne, ioZero} <= io;
		testPin <= t;
		tick(3);
	endtask

	initial begin
		doReset();
		check(flashStatus.ready, 1, "ready after reset");
		check(flashStatus.lock_violation_flag, 0, "lock flag");
		check(bankStandby, 2'h3, "standby after reset");
		check(lockBits, 0, "locks after reset");
		check(calibration, 8'hA5, "calibration value");
		// miss then prefetch hit on the next halfword
		@(posedge clock);
		waitStates <= 2'h3;
		readWord(21'h000100, 0, lat);
		check(readData, wordAt(21'h000100), "read data");
		readWord(21'h000102, 0, lat2);
		check(readData, wordAt(21'h000102), "halfword read");
		check(lat2 < lat, 1, "prefetch hit not faster");
		tick(2);
		check(bankStandby, 2'h3, "standby after reads");
		// lock two regions, then a program into one is aborted
		issue(CMD_SET_LOCK, 11'd0, 0);
		issue(CMD_SET_LOCK, 11'd64, 0);
		tick(1);
		check(lockBits[1:0], 2'h3, "64-page regions");
		@(posedge clock);
		for (int i = 0; i < 4; i++) begin
			bufWrite <= 1;
			bufWordAddr <= 6'(i);
			bufWriteData <= 32'hC0DE0000 + 32'(i);
			@(posedge clock);
		end
		bufWrite <= 0;
		issue(CMD_PAGE_PROGRAM, 11'd3, 0);
		tick(1);
		check(flashStatus.lock_violation_flag, 1, "locked prog");
		check(flashStatus.ready, 1, "ready after abort");
		check(bankBusy, 2'h0, "abort started array");
		check(flashStatus.irq, 0, "irq while disabled");
		issue(CMD_CLEAR_LOCK, 11'd0, 0);
		tick(1);
		check(lockBits[1:0], 2'h2, "clear lock");
		// program bank 0 while bank 1 is read
		issue(CMD_PAGE_PROGRAM, 11'd3, 0);
		tick(1);
		check(flashStatus.ready, 0, "ready while busy");
		check(bankBusy, 2'h1, "bank 0 busy");
		readWord(21'h100200, 0, lat);
		check(readData, wordAt(21'h100200), "other bank read");
		check(lat < 8, 1, "other bank read stalled");
		check(bankStandby, 2'h2, "standby per bank");
		waitReady();
		check(bankBusy, 2'h0, "busy after program");
		check(programData, 32'hC0DE0000, "buffer word 0");
		@(posedge clock);
		lockErrIrqEn <= 1;
		issue(CMD_PAGE_PROGRAM, 11'd64, 0);
		tick(1);
		check(flashStatus.irq, 1, "lock error irq");
		// unknown command, then completion irq
		doReset();
		issue(command_t'(4'hF), 11'd0, 0);
		tick(1);
		check(flashStatus.commandError, 1, "unknown command");
		doReset();
		@(posedge clock);
		doneIrqEn <= 1;
		issue(CMD_PAGE_ERASE, 11'd5, 0);
		waitReady();
		tick(2);
		check(flashStatus.irq, 1, "done irq");
		// general purpose bits
		issue(CMD_SET_GP, 11'd0, 0);
		issue(CMD_SET_GP, 11'd0, 1);
		tick(1);
		check(brownoutEn, 1, "gp0 set");
		check(brownoutRst, 1, "gp1 set");
		issue(CMD_CLEAR_GP, 11'd0, 1);
		tick(1);
		check(brownoutRst, 0, "gp1 clear");
		check(brownoutEn, 1, "gp0 kept");
		issue(CMD_SET_GP, 11'd0, 1);
		// security blocks debug and fast port only
		issue(CMD_SET_SECURITY, 11'd0, 0);
		tick(1);
		check(securityBit, 1, "security set");
		readWord(21'h000040, 1, lat);
		check(readRefused, 1, "secure debug read");
		readWord(21'h000040, 0, lat);
		check(readValid, 1, "secure core read");
		setStraps(3'h3, 1);
		check(fastPort, 0, "fast port while secure");
		issue(CMD_FULL_ERASE, 11'd0, 0);
		waitReady();
		check(securityBit, 1, "erase without pin");
		issue(CMD_SET_LOCK, 11'd200, 0);
		// the block counts no minimum hold, so the bench scales it down
		@(posedge clock);
		erasePin <= 1;
		tick(64);
		@(posedge clock);
		erasePin <= 0;
		tick(2);
		check(lockBits, 0, "pin clears locks");
		check(brownoutEn, 0, "pin clears gp0");
		check(brownoutRst, 0, "pin clears gp1");
		check(calibration, 8'hA5, "calibration kept");
		check(securityBit, 1, "pin alone");
		// a page erase after the pin must not release security
		issue(CMD_PAGE_ERASE, 11'd5, 0);
		waitReady();
		tick(2);
		check(securityBit, 1, "page erase after pin");
		issue(CMD_FULL_ERASE, 11'd0, 0);
		waitReady();
		tick(2);
		check(securityBit, 0, "security cleared");
		check(fastPort, 1, "fast port entry");
		readWord(21'h000040, 1, lat);
		check(readValid, 1, "debug read after clear");
		// boot recovery straps
		setStraps(3'h7, 1);
		check(fastPort, 0, "fast port with line two");
		check(bootRestore, 0, "early boot restore");
		tick(25);
		check(bootRestore, 1, "boot restore");
		conclude();
	end
endmodule
